// file: rtl/psfc_device.sv
// Control and fault logic of the four-channel low-side predriver.
// Assumes all link pins and sense inputs are asynchronous to CLK_SYS.
`timescale 1ns/1ps

module psfc_device
   import psfc_pkg::*;
#(
   parameter bit LATCH_OFF = 1'b1, // 1 latch-off, 0 retry variant.
   parameter int TICK = TICK_CYC, // System cycles per timebase tick.
   parameter logic [TMR_W-1:0] MASK_T = TMR_W'(MASK_US), // Mask ticks.
   parameter logic [TMR_W-1:0] DG_T = TMR_W'(DEGLITCH_US), // Deglitch.
   parameter logic [TMR_W-1:0] PULSE_T = TMR_W'(PULSE_US), // Retry on.
   parameter logic [TMR_W-1:0] PERIOD_T = TMR_W'(PERIOD_US) // Retry period.
)(
   psfc_link_if.dev LINK, // Serial, parallel and flag pins.
   input wire logic CLK_SYS, // System clock.
   input wire logic RST_N, // Synchronous reset, active low.
   input wire logic [3:0] DRAIN_SENSE_IN, // 1: drain above reference.
   input wire logic BATT_OVER_IN, // 1: battery overvoltage.
   output logic [3:0] GATE_DRIVE_OUT // Gate drive per channel.
);

   // ------------------------------------------------------------------
   // Input synchronisers and filter
   // ------------------------------------------------------------------
   logic [IN_W-1:0] s1;
   logic [IN_W-1:0] s2;
   logic [IN_W-1:0] s3;
   logic [IN_W-1:0] filt;
   logic [IN_W-1:0] filt_d;
   logic [IN_W-1:0] next_filt;
   logic [IN_W-1:0] raw;

   assign raw = {BATT_OVER_IN, DRAIN_SENSE_IN, LINK.parallel_channel_in,
                 LINK.sdi, LINK.cs_n, LINK.sclk};

   // A bit only moves once the second and third stages agree.
   always_comb begin
      next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         s1 <= IN_RST;
         s2 <= IN_RST;
         s3 <= IN_RST;
         filt <= IN_RST;
         filt_d <= IN_RST;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
         filt_d <= filt;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic cs_low;
   logic sdi_f;
   logic ov_f;
   logic [3:0] par_f;
   logic [3:0] drn_f;

   assign sclk_rise = filt[IN_SCLK] & ~filt_d[IN_SCLK];
   assign sclk_fall = ~filt[IN_SCLK] & filt_d[IN_SCLK];
   assign cs_fall = ~filt[IN_CS] & filt_d[IN_CS];
   assign cs_rise = filt[IN_CS] & ~filt_d[IN_CS];
   assign cs_low = ~filt[IN_CS];
   assign sdi_f = filt[IN_SDI];
   assign ov_f = filt[IN_OV];
   assign par_f = filt[IN_PAR +: 4];
   assign drn_f = filt[IN_DRN +: 4];

   // ------------------------------------------------------------------
   // Free-running timebase
   // ------------------------------------------------------------------
   logic [TB_W-1:0] tb;
   logic [TB_W-1:0] next_tb;
   logic tick;

   // One shared prescaler keeps the four channel timers cheap.
   always_comb begin
      tick = (tb == TB_W'(TICK - 1));
      next_tb = tick ? '0 : tb + 1'b1;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         tb <= '0;
      end else begin
         tb <= next_tb;
      end
   end

   // ------------------------------------------------------------------
   // Per-channel gate and fault timers
   // ------------------------------------------------------------------
   logic [3:0] ctrl;
   psfc_ch_t st [PSFC_CH];
   psfc_ch_t next_st [PSFC_CH];
   logic [TMR_W-1:0] tmr [PSFC_CH];
   logic [TMR_W-1:0] next_tmr [PSFC_CH];
   logic [TMR_W-1:0] dg [PSFC_CH];
   logic [TMR_W-1:0] next_dg [PSFC_CH];
   logic [TMR_W-1:0] rt [PSFC_CH];
   logic [TMR_W-1:0] next_rt [PSFC_CH];
   logic next_gate [PSFC_CH];

   genvar gi;
   generate
      for (gi = 0; gi < PSFC_CH; gi++) begin : g_ch
         logic req;
         logic mask_ok;
         logic g;

         // Each channel has its own mask, deglitch and retry counters.
         always_comb begin
            req = par_f[gi] | ctrl[gi];
            mask_ok = (tmr[gi] >= MASK_T);
            next_st[gi] = st[gi];
            next_dg[gi] = '0;
            next_rt[gi] = '0;
            g = 1'b0;
            case (st[gi])
               PSFC_RUN: begin
                  g = req;
                  if (GATE_DRIVE_OUT[gi] && mask_ok && drn_f[gi] &&
                      !ov_f) begin
                     next_dg[gi] = dg[gi] + TMR_W'(tick);
                  end
                  if (GATE_DRIVE_OUT[gi] && (dg[gi] >= DG_T)) begin
                     next_st[gi] = PSFC_SHORT;
                     g = 1'b0;
                     next_rt[gi] = PULSE_T;
                  end
               end
               PSFC_SHORT: begin
                  if (!req) begin
                     next_st[gi] = PSFC_RUN;
                  end else if (!LATCH_OFF) begin
                     g = (rt[gi] < PULSE_T);
                     next_rt[gi] = rt[gi];
                     if (tick) begin
                        next_rt[gi] = (rt[gi] == PERIOD_T - 1'b1) ?
                                      '0 : rt[gi] + 1'b1;
                     end
                     // The mask ends inside the pulse, so it probes once.
                     if (GATE_DRIVE_OUT[gi] && mask_ok && !drn_f[gi]) begin
                        next_st[gi] = PSFC_RUN;
                     end
                  end
               end
               default: begin
                  next_st[gi] = PSFC_RUN;
               end
            endcase
            if (ov_f) begin
               g = 1'b0;
            end
            next_gate[gi] = g;
            // Every gate edge restarts the mask for short or open checks.
            if (g != GATE_DRIVE_OUT[gi]) begin
               next_tmr[gi] = '0;
            end else if (tick && (tmr[gi] != '1)) begin
               next_tmr[gi] = tmr[gi] + 1'b1;
            end else begin
               next_tmr[gi] = tmr[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK_SYS) begin
      for (int k = 0; k < PSFC_CH; k++) begin
         if (!RST_N) begin
            st[k] <= PSFC_RUN;
            tmr[k] <= '0;
            dg[k] <= '0;
            rt[k] <= '0;
            GATE_DRIVE_OUT[k] <= 1'b0;
         end else begin
            st[k] <= next_st[k];
            tmr[k] <= next_tmr[k];
            dg[k] <= next_dg[k];
            rt[k] <= next_rt[k];
            GATE_DRIVE_OUT[k] <= next_gate[k];
         end
      end
   end

   // ------------------------------------------------------------------
   // Serial shift register, control latch and fault flag
   // ------------------------------------------------------------------
   logic [3:0] sreg;
   logic [3:0] next_sreg;
   logic [3:0] next_ctrl;
   logic [3:0] fault;
   logic short_any;
   logic hold;
   logic next_hold;
   logic next_sdo;
   logic next_sdo_oe;
   logic next_flt_oe;

   // Open load and overvoltage are held until a frame reads them out.
   always_comb begin
      short_any = 1'b0;
      for (int k = 0; k < PSFC_CH; k++) begin
         fault[k] = ((st[k] == PSFC_SHORT) ||
                     (!GATE_DRIVE_OUT[k] && (tmr[k] >= MASK_T) &&
                      !drn_f[k])) && !ov_f;
         short_any = short_any | ((st[k] == PSFC_SHORT) && !ov_f);
      end
      next_sreg = sreg;
      next_ctrl = ctrl;
      next_sdo = LINK.sdo_out;
      next_sdo_oe = LINK.sdo_oe;
      if (cs_fall) begin
         next_sreg = fault;
         next_sdo = fault[3];
         next_sdo_oe = 1'b1;
      end else if (cs_rise) begin
         next_ctrl = sreg;
         next_sreg = '0;
         next_sdo_oe = 1'b0;
      end else if (cs_low) begin
         if (sclk_rise) begin
            next_sreg = {sreg[2:0], sdi_f};
         end
         if (sclk_fall) begin
            next_sdo = sreg[3];
         end
      end
      // A new event wins over the release at select fall.
      next_hold = (|fault) | ov_f | (hold & ~cs_fall);
      next_flt_oe = short_any | next_hold;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sreg <= '0;
         ctrl <= CTRL_RST;
         hold <= 1'b0;
         LINK.sdo_out <= 1'b0;
         LINK.sdo_oe <= 1'b0;
         LINK.fault_flag_out <= 1'b0;
         LINK.fault_flag_oe <= 1'b0;
      end else begin
         sreg <= next_sreg;
         ctrl <= next_ctrl;
         hold <= next_hold;
         LINK.sdo_out <= next_sdo;
         LINK.sdo_oe <= next_sdo_oe;
         LINK.fault_flag_out <= 1'b0; // Open drain: only pulls low.
         LINK.fault_flag_oe <= next_flt_oe;
      end
   end

endmodule

// file: rtl/psfc_host.sv
// Microcontroller end: APB registers drive serial frames and parallel pins.
// Assumes the device samples the link with its own synchronisers.
`timescale 1ns/1ps

module psfc_host
   import psfc_pkg::*;
#(
   parameter int HALF = SCLK_HALF_CYC // Cycles per serial clock half.
)(
   psfc_link_if.host LINK, // Serial, parallel and flag pins.
   input wire logic CLK_SYS, // System clock.
   input wire logic RST_N, // Synchronous reset, active low.
   input wire logic PSEL, // APB select.
   input wire logic PENABLE, // APB enable.
   input wire logic PWRITE, // APB direction, 1 write.
   input wire logic [7:0] PADDR, // APB byte address.
   input wire logic [31:0] PWDATA, // APB write data.
   output logic [31:0] PRDATA, // APB read data.
   output logic PREADY, // APB ready.
   output logic PSLVERR // APB error on unmapped address.
);

   function automatic logic mapped(input logic [7:0] a);
      return (a == A_CMD) || (a == A_PAR) || (a == A_STAT);
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers for the serial output and fault flag
   // ------------------------------------------------------------------
   logic [1:0] s1;
   logic [1:0] s2;
   logic [1:0] s3;
   logic [1:0] filt;
   logic [1:0] next_filt;

   always_comb begin
      next_filt = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
   end

   // ------------------------------------------------------------------
   // Frame sequencer and APB slave
   // ------------------------------------------------------------------
   psfc_host_t st;
   psfc_host_t next_st;
   logic [7:0] div;
   logic [7:0] next_div;
   logic [3:0] left;
   logic [3:0] next_left;
   logic [7:0] txd;
   logic [7:0] next_txd;
   logic [7:0] rx;
   logic [7:0] next_rx;
   logic next_sclk;
   logic next_cs_n;
   logic next_sdi;
   logic [3:0] next_par;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic access;
   logic wr;
   logic step;
   logic [3:0] len;

   // Writes land only on the edge that completes the access phase.
   always_comb begin
      access = PSEL & PENABLE;
      wr = access & PREADY & PWRITE;
      next_pready = access & ~PREADY;
      next_pslverr = access & ~PREADY & ~mapped(PADDR);
      next_prdata = PRDATA;
      if (access && !PREADY && !PWRITE) begin
         next_prdata = '0;
         case (PADDR)
            A_PAR: next_prdata[3:0] = LINK.parallel_channel_in;
            A_STAT: begin
               next_prdata[STAT_BUSY] = (st != PSFC_IDLE);
               next_prdata[STAT_FLT] = ~filt[1];
               next_prdata[STAT_RX_LSB +: 8] = rx;
            end
            default: next_prdata = '0;
         endcase
      end
      next_par = LINK.parallel_channel_in;
      if (wr && PADDR == A_PAR) begin
         next_par = PWDATA[3:0];
      end
      len = PWDATA[CMD_LEN_LSB +: 4];
      step = (div == 8'(HALF - 1));
      next_div = step ? '0 : div + 1'b1;
      next_st = st;
      next_left = left;
      next_txd = txd;
      next_rx = rx;
      next_sclk = LINK.sclk;
      next_cs_n = LINK.cs_n;
      next_sdi = LINK.sdi;
      case (st)
         PSFC_IDLE: begin
            next_div = '0;
            // A command arriving mid-frame is dropped.
            if (wr && PADDR == A_CMD) begin
               next_txd = PWDATA[7:0];
               next_left = (len == 4'h0 || len > 4'(FRAME_MAX)) ?
                           4'(FRAME_MAX) : len;
               next_rx = '0;
               next_cs_n = 1'b0;
               next_sdi = PWDATA[7];
               next_st = PSFC_LEAD;
            end
         end
         PSFC_LEAD, PSFC_LOW: begin
            if (step) begin
               next_sclk = 1'b1;
               next_st = PSFC_HIGH;
            end
         end
         PSFC_HIGH: begin
            // Sample late in the high half to cover both sync chains.
            if (step) begin
               next_rx = {rx[6:0], filt[0]};
               next_sclk = 1'b0;
               next_txd = {txd[6:0], 1'b0};
               next_sdi = txd[6];
               next_left = left - 1'b1;
               next_st = (left == 4'h1) ? PSFC_TRAIL : PSFC_LOW;
            end
         end
         PSFC_TRAIL: begin
            if (step) begin
               next_cs_n = 1'b1;
               next_st = PSFC_IDLE;
            end
         end
         default: begin
            next_st = PSFC_IDLE;
            next_cs_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         s1 <= 2'h2;
         s2 <= 2'h2;
         s3 <= 2'h2;
         filt <= 2'h2;
         st <= PSFC_IDLE;
         div <= '0;
         left <= '0;
         txd <= '0;
         rx <= '0;
         PRDATA <= '0;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         LINK.sclk <= 1'b0;
         LINK.cs_n <= 1'b1;
         LINK.sdi <= 1'b0;
         LINK.parallel_channel_in <= '0;
      end else begin
         s1 <= {LINK.fault_flag_n, LINK.sdo};
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
         st <= next_st;
         div <= next_div;
         left <= next_left;
         txd <= next_txd;
         rx <= next_rx;
         PRDATA <= next_prdata;
         PREADY <= next_pready;
         PSLVERR <= next_pslverr;
         LINK.sclk <= next_sclk;
         LINK.cs_n <= next_cs_n;
         LINK.sdi <= next_sdi;
         LINK.parallel_channel_in <= next_par;
      end
   end

endmodule

// file: shared/psfc_link_if.sv
// Pin bundle between the microcontroller end and the predriver end.
// Assumes the serial output and fault flag are resolved here from enables.
`timescale 1ns/1ps

interface psfc_link_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic [3:0] parallel_channel_in;
   logic sdo_out;
   logic sdo_oe;
   logic sdo;
   logic fault_flag_out;
   logic fault_flag_oe;
   logic fault_flag_n;

   // An undriven serial output reads low; the flag line has a pull-up.
   assign sdo = sdo_oe ? sdo_out : 1'b0;
   assign fault_flag_n = fault_flag_oe ? fault_flag_out : 1'b1;

   modport dev (
      input sclk, cs_n, sdi, parallel_channel_in,
      output sdo_out, sdo_oe, fault_flag_out, fault_flag_oe
   );

   modport host (
      output sclk, cs_n, sdi, parallel_channel_in,
      input sdo, fault_flag_n
   );
endinterface

// file: shared/psfc_pkg.sv
// Constants and types shared by both ends of the predriver serial link.
// Assumes a 25 MHz system clock on both ends and a 1 us internal timebase.
//
// Functional notes
// - Rising serial clock shifts input into LSB.
// - Host clocks one to eight bits per frame.
// - Four faults out first, last four in apply.
// - Select rise: latch control, tri-state, re-arm.
// - Control bit zero off, one on.
// - Fault MSB at select fall, rest on falls.
// - Faults captured only at select falling edge.
// - Fault bit n reports channel n.
// - Latch-off short clears by off-then-on toggle.
// - Retry variant clears fault once short gone.
// - Gate on when parallel or serial requests.
// - Parallel inputs act without serial activity.
// - Parallel low-then-high clears shorted gate.
// - Turn-on starts 60 us short mask.
// - Short held 8 us flags, latch-off kills gate.
// - Retry pulses 68 us every 10 ms.
// - Host serial clock at most 10 MHz.
// - Host reads faults once after power-up.
// - Open load checked off, after mask time.
// - Flag released at select fall if clear.
// - Overvoltage flags, hides load faults, forces off.

package psfc_pkg;

   // ------------------------------------------------------------------
   // Sizes and clocking
   // ------------------------------------------------------------------
   localparam int PSFC_CH = 4;
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int TICK_CYC = CLK_HZ / 1_000_000;
   localparam int TB_W = 16;
   localparam int TMR_W = 14;

   // ------------------------------------------------------------------
   // Fault timing, in microsecond ticks
   // ------------------------------------------------------------------
   localparam int MASK_US = 60;
   localparam int DEGLITCH_US = 8;
   localparam int PULSE_US = 68;
   localparam int PERIOD_MS = 10;
   localparam int PERIOD_US = PERIOD_MS * 1000;

   // ------------------------------------------------------------------
   // Serial link timing, made by the host divider
   // ------------------------------------------------------------------
   localparam int SCLK_PERIOD_NS = 640;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / CLK_PERIOD_NS / 2;
   localparam int FRAME_MAX = 8;

   // ------------------------------------------------------------------
   // Device input synchroniser layout and reset value
   // ------------------------------------------------------------------
   localparam int IN_W = 12;
   localparam int IN_SCLK = 0;
   localparam int IN_CS = 1;
   localparam int IN_SDI = 2;
   localparam int IN_PAR = 3;
   localparam int IN_DRN = 7;
   localparam int IN_OV = 11;
   localparam logic [IN_W-1:0] IN_RST = 12'h002;
   localparam logic [3:0] CTRL_RST = 4'h0;

   // ------------------------------------------------------------------
   // Host register map and fields
   // ------------------------------------------------------------------
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_PAR = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam int CMD_LEN_LSB = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_FLT = 1;
   localparam int STAT_RX_LSB = 8;

   // ------------------------------------------------------------------
   // State types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PSFC_RUN = 2'b01,
      PSFC_SHORT = 2'b10
   } psfc_ch_t;

   typedef enum logic [4:0] {
      PSFC_IDLE = 5'b00001,
      PSFC_LEAD = 5'b00010,
      PSFC_HIGH = 5'b00100,
      PSFC_LOW = 5'b01000,
      PSFC_TRAIL = 5'b10000
   } psfc_host_t;

endpackage

// file: tb/psfc_checker.sv
// Assertions on the first link between the host and device ends.
// Assumes the link signals and CLK_SYS are wired in by name.
`timescale 1ns/1ps

module psfc_checker (
   input wire logic CLK_SYS, // System clock.
   input wire logic RST_N, // Reset, active low.
   input wire logic sclk, // Serial clock.
   input wire logic cs_n, // Chip select, active low.
   input wire logic sdi, // Serial data to device.
   input wire logic sdo_out, // Serial data from device.
   input wire logic sdo_oe, // Serial output enable.
   input wire logic fault_flag_out, // Flag drive level.
   input wire logic fault_flag_oe // Flag pull-down enable.
);
   // ------
   // Edge age
   // ------
   logic prev_sclk;
   logic prev_cs_n;
   logic [3:0] age;
   logic [3:0] next_age;

   // Restarts on a clock fall or select edge, so sdo moves are traced.
   always_comb begin
      next_age = (age == 4'hf) ? age : age + 4'h1;
      if ((prev_sclk && !sclk) || (prev_cs_n != cs_n)) begin
         next_age = 4'h0;
      end
      if (!RST_N) begin
         next_age = 4'hf;
      end
   end

   // Registers only.
   always_ff @(posedge CLK_SYS) begin
      prev_sclk <= sclk;
      prev_cs_n <= cs_n;
      age <= next_age;
   end

   // ------
   // Properties
   // ------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);

   sequence s_deselected;
      cs_n [*8];
   endsequence
   sequence s_select;
      $fell(cs_n);
   endsequence

   property p_sdo_release;
      s_deselected |-> !sdo_oe;
   endproperty
   a_sdo_release: assert property (p_sdo_release)
      else $error("serial output driven while deselected");

   property p_sdo_drive;
      s_select |-> ##[1:7] sdo_oe;
   endproperty
   a_sdo_drive: assert property (p_sdo_drive)
      else $error("serial output not driven after select");

   property p_sdo_move;
      sdo_oe && $past(sdo_oe) && $changed(sdo_out) |-> age <= 4'h8;
   endproperty
   a_sdo_move: assert property (p_sdo_move)
      else $error("serial output moved away from a clock fall");

   property p_sclk_high;
      $rose(sclk) |-> sclk [*2];
   endproperty
   a_sclk_high: assert property (p_sclk_high)
      else $error("serial clock high phase too short");

   property p_sclk_low;
      $fell(sclk) |-> !sclk [*2];
   endproperty
   a_sclk_low: assert property (p_sclk_low)
      else $error("serial clock low phase too short");

   property p_sclk_still;
      cs_n |-> !sclk;
   endproperty
   a_sclk_still: assert property (p_sclk_still)
      else $error("serial clock high outside a frame");

   property p_sdi_hold;
      sclk && $past(sclk) |-> $stable(sdi);
   endproperty
   a_sdi_hold: assert property (p_sdi_hold)
      else $error("serial input moved while clock high");

   property p_flag_od;
      fault_flag_oe |-> !fault_flag_out;
   endproperty
   a_flag_od: assert property (p_flag_od)
      else $error("fault flag driven high");
endmodule

// file: tb/testbench.sv
// Self-checking bench: one APB master feeds two host and device pairs.
// Assumes pair a is the latch-off variant and pair b the retry one.
`timescale 1ns/1ps

module testbench
   import psfc_pkg::*;
;
   // ------
   // Signals and model state
   // ------
   localparam int TK = 2; // System cycles per tick.
   localparam int PW = 8; // Retry pulse, ticks.
   localparam int PR = 40; // Retry period, ticks.
   localparam int MK = 6; // Short mask, ticks.
   localparam int DG = 2; // Short deglitch, ticks.
   logic clk;
   logic rst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] drain;
   logic batt_over;
   logic [3:0] gate_a;
   logic [3:0] gate_b;
   logic [3:0] ctrl;
   logic [3:0] par;
   logic [31:0] rd;
   logic er;
   int err_count;
   int total_checks;
   int c;

   psfc_link_if link_a ();
   psfc_link_if link_b ();

   // Both hosts see the same APB traffic, so both devices get every frame.
   psfc_host i_psfc_host (.LINK(link_a), .CLK_SYS(clk), .RST_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr));
   psfc_host i_psfc_host_b (.LINK(link_b), .CLK_SYS(clk), .RST_N(rst_n),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR());
   psfc_device #(.LATCH_OFF(1'b1), .TICK(TK), .MASK_T(TMR_W'(MK)),
      .DG_T(TMR_W'(DG)), .PULSE_T(TMR_W'(PW)), .PERIOD_T(TMR_W'(PR)))
      i_psfc_device (.LINK(link_a), .CLK_SYS(clk), .RST_N(rst_n),
      .DRAIN_SENSE_IN(drain), .BATT_OVER_IN(batt_over),
      .GATE_DRIVE_OUT(gate_a));
   psfc_device #(.LATCH_OFF(1'b0), .TICK(TK), .MASK_T(TMR_W'(MK)),
      .DG_T(TMR_W'(DG)), .PULSE_T(TMR_W'(PW)), .PERIOD_T(TMR_W'(PR)))
      i_psfc_device_b (.LINK(link_b), .CLK_SYS(clk), .RST_N(rst_n),
      .DRAIN_SENSE_IN(drain), .BATT_OVER_IN(batt_over),
      .GATE_DRIVE_OUT(gate_b));
   psfc_checker i_psfc_checker (.CLK_SYS(clk), .RST_N(rst_n),
      .sclk(link_a.sclk), .cs_n(link_a.cs_n), .sdi(link_a.sdi),
      .sdo_out(link_a.sdo_out), .sdo_oe(link_a.sdo_oe),
      .fault_flag_out(link_a.fault_flag_out),
      .fault_flag_oe(link_a.fault_flag_oe));

   // ------
   // Tasks
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic hang();
      err_count++;
      $display("ERROR %0t: wait ran out", $time);
      wrap_up();
   endtask

   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Sends a frame, then polls status until the host is idle.
   task automatic frame(input logic [7:0] tx, input int n);
      int k;
      apb(1'b1, A_CMD, {20'h0, 4'(n), tx});
      k = 0;
      do begin
         apb(1'b0, A_STAT, 32'h0);
         k++;
      end while (rd[STAT_BUSY] !== 1'b0 && k < 60);
      if (k >= 60) hang();
   endtask

   // Only never-on channels may see a high drain, so nothing shorts.
   task automatic step(input logic [7:0] tx, input int n,
                       input logic [3:0] np);
      logic [11:0] v;
      logic [7:0] mk;
      logic [3:0] d;
      logic [3:0] f;
      d = 4'($urandom) & ~(ctrl | par | np | 4'(12'(tx) >> (8 - n)));
      drain <= d;
      par = np;
      apb(1'b1, A_PAR, {28'h0, np});
      repeat (40) @(posedge clk);
      chk(gate_a, ctrl | par);
      f = ~(ctrl | par) & ~d;
      v = {f, tx};
      mk = 8'((1 << n) - 1);
      frame(tx, n);
      chk(rd[15:8] & mk, 8'(v >> (12 - n)) & mk);
      ctrl = 4'(v >> (8 - n));
      repeat (40) @(posedge clk);
      chk(gate_a, ctrl | par);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[STAT_FLT], (f != 4'h0) || ((~(ctrl | par) & ~d) != 4'h0));
   endtask

   task automatic until_b(input logic lvl);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (gate_b[0] !== lvl && c < 300);
      if (c >= 300) hang();
   endtask

   // ------
   // Clock, watchdog and sequence
   // ------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      hang();
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      drain = 4'hf;
      batt_over = 1'b0;
      ctrl = 4'h0;
      par = 4'h0;
      err_count = 0;
      total_checks = 0;
      void'($urandom(30108));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      chk(gate_a, 4'h0);
      apb(1'b0, A_PAR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(er, 1'b1);
      $display("test reset done");
      step(8'ha5, 8, 4'h0);
      repeat (8) step(8'($urandom), int'(1 + $urandom % 8), 4'($urandom));
      step(8'h00, 8, 4'h0);
      $display("test frames done");
      drain <= 4'hf;
      apb(1'b1, A_PAR, 32'h1);
      repeat (12) @(posedge clk);
      chk(gate_a[0] & gate_b[0], 1'b1);
      repeat (33) @(posedge clk);
      chk(gate_a[0], 1'b0);
      chk(link_a.fault_flag_n, 1'b0);
      chk(link_b.fault_flag_n, 1'b0);
      until_b(1'b1);
      until_b(1'b0);
      chk(32'(c >= PW * TK - 2 && c <= PW * TK + 2), 1);
      until_b(1'b1);
      chk(32'(c >= (PR - PW) * TK - 2 && c <= (PR - PW) * TK + 2), 1);
      frame(8'h00, 4);
      chk(rd[11:8], 4'h1);
      drain <= 4'he;
      repeat (200) @(posedge clk);
      chk(gate_b[0], 1'b1);
      chk(gate_a[0], 1'b0);
      apb(1'b1, A_PAR, 32'h0);
      repeat (20) @(posedge clk);
      apb(1'b1, A_PAR, 32'h1);
      repeat (20) @(posedge clk);
      chk(gate_a[0], 1'b1);
      $display("test short done");
      batt_over <= 1'b1;
      repeat (20) @(posedge clk);
      chk(gate_a | gate_b, 4'h0);
      chk(link_a.fault_flag_n, 1'b0);
      frame(8'h00, 4);
      chk(rd[11:8], 4'h0);
      batt_over <= 1'b0;
      $display("test overvoltage done");
      wrap_up();
   end
endmodule
